// *** eec_pkg.sv ***
// eec_pkg: shared constants, encodings and carrier types of the
// three-wire serial nonvolatile memory command engine.
// assumes a 25 MHz system clock beside the serial shift clock.
package eec_pkg;

  localparam int          CLK_HZ        = 25_000_000;
  localparam int          TWP_MS        = 5;
  localparam int          TWP_CYC_DEF   = TWP_MS * (CLK_HZ / 1000);
  localparam int          MIN_SEL_LOW_NS = 250;
  localparam int          CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int          SEL_LOW_CYC   =
    (MIN_SEL_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int          TMR_W         = 17;
  localparam int          LOW_W         = 4;

  localparam int          NUM_BYTES     = 512;
  localparam logic [4:0]  OPC_LEN       = 5'h02;
  localparam logic [4:0]  ADDR_LEN_BYTE = 5'h09;
  localparam logic [4:0]  ADDR_LEN_WORD = 5'h08;
  localparam logic [4:0]  DATA_LEN_BYTE = 5'h08;
  localparam logic [4:0]  DATA_LEN_WORD = 5'h10;

  localparam logic [1:0]  OPC_READ      = 2'h2;
  localparam logic [1:0]  OPC_WRITE     = 2'h1;
  localparam logic [1:0]  OPC_ERASE     = 2'h3;
  localparam logic [1:0]  OPC_EXT       = 2'h0;
  localparam logic [1:0]  SUB_ENABLE    = 2'h3;
  localparam logic [1:0]  SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0]  SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0]  SUB_DISABLE   = 2'h0;

  localparam logic        START_MARKER_BIT = 1'b1;
  localparam logic        DUMMY_BIT     = 1'b0;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

  typedef enum logic [2:0] {
    OP_ENABLE    = 3'b000,
    OP_DISABLE   = 3'b001,
    OP_ERASE     = 3'b010,
    OP_WRITE     = 3'b011,
    OP_ERASE_ALL = 3'b100,
    OP_WRITE_ALL = 3'b101,
    OP_READ      = 3'b110
  } eec_op_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_OPC  = 3'b001,
    L_ADDR = 3'b010,
    L_DATA = 3'b011,
    L_READ = 3'b100,
    L_DONE = 3'b101
  } eec_lstate_t;

  typedef struct packed {
    eec_op_t     op;
    logic        wide;
    logic [8:0]  addr;
    logic [15:0] data;
  } eec_req_t;

endpackage

// *** eec_array.sv ***
// eec_array: the storage array as flip-flops, one byte per slot.
// assumes write requests come from the system clock domain only and
// that the read address is held still while the array is changing.
`timescale 1ns/1ps
module eec_array (
  input  wire logic              clk,
  input  wire logic              commit,
  input  wire eec_pkg::eec_req_t cmd,
  input  wire logic              rd_wide,
  input  wire logic [8:0]        rd_addr,
  output logic [15:0]            rd_data
);
  import eec_pkg::*;

  logic [7:0] mem_q [NUM_BYTES];

  // word slot w uses bytes 2w (low half) and 2w+1 (high half)
  function automatic logic [8:0] byte_idx(input logic wide,
                                          input logic [8:0] a,
                                          input logic hi);
    byte_idx = wide ? {a[7:0], hi} : a;
  endfunction

  always_comb begin
    if (rd_wide) begin
      rd_data = {mem_q[byte_idx(1'b1, rd_addr, 1'b1)],
                 mem_q[byte_idx(1'b1, rd_addr, 1'b0)]};
    end else begin
      rd_data = {8'h00, mem_q[rd_addr]};
    end
  end

  // contents survive reset on purpose: the array models retention
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BYTES; gi++) begin : g_byte
      localparam logic [8:0] IDX = 9'(gi);
      logic       one_hit;
      logic [7:0] wr_byte;
      always_comb begin
        one_hit = (IDX == byte_idx(cmd.wide, cmd.addr, 1'b0)) ||
                  (cmd.wide && IDX == byte_idx(1'b1, cmd.addr, 1'b1));
        wr_byte = (cmd.wide && IDX[0]) ? cmd.data[15:8] : cmd.data[7:0];
      end
      always_ff @(posedge clk) begin
        if (commit) begin
          case (cmd.op)
            OP_ERASE: begin
              if (one_hit) begin
                mem_q[gi] <= ERASED_BYTE;
              end
            end
            OP_WRITE: begin
              if (one_hit) begin
                mem_q[gi] <= wr_byte;
              end
            end
            OP_ERASE_ALL: begin
              mem_q[gi] <= ERASED_BYTE;
            end
            OP_WRITE_ALL: begin
              mem_q[gi] <= wr_byte;
            end
            default: begin
              mem_q[gi] <= mem_q[gi];
            end
          endcase
        end
      end
    end
  endgenerate

endmodule

// *** eec_engine.sv ***
// eec_engine: command engine of a three-wire serial memory, shift
// clock domain for the link, system clock domain for the enable latch,
// the self-timed program cycle and the ready/busy status.
// assumes chip select and serial input meet setup to the shift clock.
`timescale 1ns/1ps
// How it works
// - frame starts with select, marker one, opcode
// - read opcode 10 then 9 or 8 address
// - enable: opcode 00 with leading bits 11
// - erase opcode 11 with full address
// - write opcode 01, address, 8 or 16 data
// - erase-all: 00 with 10, array set ones
// - write-all: 00 with 01, then one word
// - disable: 00 with 00, blocks programming
// - read output changes on rising shift edges
// - dummy zero first, then word msb first
// - sequential read increments address, no dummy
// - programming disabled after power-on reset
// - enable persists until disable or reset
// - erase sets ones, starts after address
// - select low then high shows status
// - write cycle starts after last data bit
// - status zero while busy, one when ready
// - no status if select rises after cycle
// - write-all programs every location, self-timed
// - read works whether enabled or not
// - width pin low byte, high word
// - serial output released while select low
module eec_engine #(
  parameter int unsigned TWP_CYC = eec_pkg::TWP_CYC_DEF
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic serial_shift_clock,
  input  wire logic chip_select,
  input  wire logic serial_in_line,
  input  wire logic width_select_pin,
  output logic      serial_out_line,
  output logic      serial_out_oe,
  output logic      prog_enabled,
  output logic      prog_busy
);
  import eec_pkg::*;

  // shift clock domain
  eec_lstate_t    st_q;
  eec_op_t        kind_q;
  logic [4:0]     cnt_q;
  logic [1:0]     op_q;
  logic [8:0]     ad_q;
  logic [15:0]    dt_q;
  logic [8:0]     rd_addr_q;
  logic [3:0]     rd_idx_q;
  logic           dout_q;
  logic           org_m_q;
  logic           org_s_q;
  logic           bz_m_q;
  logic           bz_s_q;
  logic           tog_q;
  eec_req_t       req_q;
  // system clock domain
  logic           cs_m_q;
  logic           cs_s_q;
  logic           cs_p_q;
  logic           tg_m_q;
  logic           tg_s_q;
  logic           tg_p_q;
  logic [LOW_W-1:0] low_q;
  logic           stat_q;
  logic           en_q;
  logic           busy_q;
  logic [TMR_W-1:0] tmr_q;
  eec_req_t       cmd_q;
  // combinational
  logic           wide;
  logic [4:0]     alen;
  logic [4:0]     wlen;
  logic [8:0]     ad_nx;
  logic [15:0]    dt_nx;
  logic [8:0]     ad_msk;
  logic [1:0]     sub;
  logic           last_addr;
  logic           last_data;
  eec_op_t        kind;
  logic           issue_now;
  logic [15:0]    rd_data;
  logic           req_edge;
  logic           commit;
  logic           cs_rise;

  localparam logic [LOW_W-1:0] LOW_MAX = LOW_W'(SEL_LOW_CYC);

  function automatic eec_op_t decode(input logic [1:0] opc,
                                     input logic [1:0] s);
    case (opc)
      OPC_READ:  decode = OP_READ;
      OPC_WRITE: decode = OP_WRITE;
      OPC_ERASE: decode = OP_ERASE;
      default: begin
        case (s)
          SUB_ENABLE:    decode = OP_ENABLE;
          SUB_ERASE_ALL: decode = OP_ERASE_ALL;
          SUB_WRITE_ALL: decode = OP_WRITE_ALL;
          default:       decode = OP_DISABLE;
        endcase
      end
    endcase
  endfunction

  // width pin is a strap, still passed through two flops
  always_ff @(posedge serial_shift_clock or negedge rst_n) begin
    if (!rst_n) begin
      org_m_q <= 1'b1;
      org_s_q <= 1'b1;
      bz_m_q  <= 1'b0;
      bz_s_q  <= 1'b0;
    end else begin
      org_m_q <= width_select_pin;
      org_s_q <= org_m_q;
      bz_m_q  <= busy_q;
      bz_s_q  <= bz_m_q;
    end
  end

  always_comb begin
    wide      = org_s_q;
    alen      = wide ? ADDR_LEN_WORD : ADDR_LEN_BYTE;
    wlen      = wide ? DATA_LEN_WORD : DATA_LEN_BYTE;
    ad_nx     = {ad_q[7:0], serial_in_line};
    dt_nx     = {dt_q[14:0], serial_in_line};
    // top bit still shifted in, only masked afterwards
    ad_msk    = wide ? {1'b0, ad_nx[7:0]} : ad_nx;
    sub       = wide ? ad_nx[7:6] : ad_nx[8:7];
    last_addr = (st_q == L_ADDR) && (cnt_q == alen - 5'h01);
    last_data = (st_q == L_DATA) && (cnt_q == wlen - 5'h01);
    kind      = decode(op_q, sub);
    issue_now = (last_addr && !bz_s_q &&
                 (kind == OP_ENABLE || kind == OP_DISABLE ||
                  kind == OP_ERASE || kind == OP_ERASE_ALL)) ||
                last_data;
  end

  // frame state ends with the select line itself, the clock may stop
  always_ff @(posedge serial_shift_clock or negedge chip_select) begin
    if (!chip_select) begin
      st_q      <= L_IDLE;
      kind_q    <= OP_DISABLE;
      cnt_q     <= 5'h00;
      op_q      <= 2'h0;
      ad_q      <= 9'h000;
      dt_q      <= 16'h0000;
      rd_addr_q <= 9'h000;
      rd_idx_q  <= 4'h0;
      dout_q    <= DUMMY_BIT;
    end else begin
      case (st_q)
        L_IDLE: begin
          if (serial_in_line == START_MARKER_BIT) begin
            st_q  <= L_OPC;
            cnt_q <= 5'h00;
          end
        end
        L_OPC: begin
          op_q <= {op_q[0], serial_in_line};
          if (cnt_q == OPC_LEN - 5'h01) begin
            st_q  <= L_ADDR;
            cnt_q <= 5'h00;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        L_ADDR: begin
          ad_q <= ad_nx;
          if (last_addr) begin
            cnt_q  <= 5'h00;
            kind_q <= kind;
            if (bz_s_q) begin
              st_q <= L_DONE;
            end else if (kind == OP_READ) begin
              st_q      <= L_READ;
              dout_q    <= DUMMY_BIT;
              rd_addr_q <= ad_msk;
              rd_idx_q  <= 4'(wlen - 5'h01);
            end else if (kind == OP_WRITE || kind == OP_WRITE_ALL) begin
              st_q <= L_DATA;
            end else begin
              st_q <= L_DONE;
            end
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        L_DATA: begin
          dt_q <= dt_nx;
          if (last_data) begin
            st_q <= L_DONE;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        L_READ: begin
          dout_q <= rd_data[rd_idx_q];
          if (rd_idx_q == 4'h0) begin
            rd_idx_q  <= 4'(wlen - 5'h01);
            rd_addr_q <= wide ? {1'b0, rd_addr_q[7:0] + 8'h01}
                              : rd_addr_q + 9'h001;
          end else begin
            rd_idx_q <= rd_idx_q - 4'h1;
          end
        end
        L_DONE: begin
          st_q <= L_DONE;
        end
        default: begin
          st_q <= L_DONE;
        end
      endcase
    end
  end

  // request word is held until the next frame issues, long after the
  // toggle has been seen on the system clock
  always_ff @(posedge serial_shift_clock or negedge rst_n) begin
    if (!rst_n) begin
      tog_q <= 1'b0;
      req_q <= '0;
    end else if (issue_now) begin
      tog_q      <= ~tog_q;
      req_q.op   <= last_data ? kind_q : kind;
      req_q.wide <= wide;
      req_q.addr <= last_data ? (wide ? {1'b0, ad_q[7:0]} : ad_q)
                              : ad_msk;
      req_q.data <= wide ? dt_nx : {8'h00, dt_nx[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_m_q <= 1'b0;
      cs_s_q <= 1'b0;
      cs_p_q <= 1'b0;
      tg_m_q <= 1'b0;
      tg_s_q <= 1'b0;
      tg_p_q <= 1'b0;
    end else begin
      cs_m_q <= chip_select;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      tg_m_q <= tog_q;
      tg_s_q <= tg_m_q;
      tg_p_q <= tg_s_q;
    end
  end

  always_comb begin
    req_edge = tg_s_q ^ tg_p_q;
    commit   = busy_q && (tmr_q == '0);
    cs_rise  = cs_s_q && !cs_p_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q   <= 1'b0;
      busy_q <= 1'b0;
      tmr_q  <= '0;
      cmd_q  <= '0;
    end else if (req_edge && !busy_q) begin
      case (req_q.op)
        OP_ENABLE: begin
          en_q <= 1'b1;
        end
        OP_DISABLE: begin
          en_q <= 1'b0;
        end
        OP_ERASE, OP_WRITE, OP_ERASE_ALL, OP_WRITE_ALL: begin
          if (en_q) begin
            busy_q <= 1'b1;
            tmr_q  <= TMR_W'(TWP_CYC - 1);
            cmd_q  <= req_q;
          end
        end
        default: begin
          en_q <= en_q;
        end
      endcase
    end else if (busy_q) begin
      if (tmr_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q - TMR_W'(1);
      end
    end
  end

  // select low time measured after sync, so short pulses show nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_q <= '0;
    end else if (cs_s_q) begin
      low_q <= '0;
    end else if (low_q != LOW_MAX) begin
      low_q <= low_q + LOW_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= 1'b0;
    end else if (!cs_s_q) begin
      stat_q <= 1'b0;
    end else if (cs_rise && busy_q && low_q == LOW_MAX) begin
      stat_q <= 1'b1;
    end
  end

  eec_array u_array (
    .clk     (clk),
    .commit  (commit),
    .cmd     (cmd_q),
    .rd_wide (wide),
    .rd_addr (rd_addr_q),
    .rd_data (rd_data)
  );

  always_comb begin
    if (st_q == L_READ) begin
      serial_out_line = dout_q;
    end else begin
      serial_out_line = stat_q & ~busy_q;
    end
    serial_out_oe = chip_select &&
                    ((st_q == L_READ) || stat_q);
    prog_enabled  = en_q;
    prog_busy     = busy_q;
  end

endmodule

// *** eec_engine_props.sv ***
// eec_engine_props: port-level timing checks of the command engine.
// assumes TWP_CYC matches the bound engine instance.
`timescale 1ns/1ps
module eec_engine_props #(
  parameter int unsigned TWP_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_shift_clock,
  input wire logic chip_select,
  input wire logic serial_in_line,
  input wire logic width_select_pin,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  input wire logic prog_enabled,
  input wire logic prog_busy
);
  logic        neg_q;
  logic        neg_oe_q;
  logic [16:0] bcnt_q;

  // value seen between rising edges, to prove no mid-cycle change
  always_ff @(negedge serial_shift_clock) begin
    neg_q    <= serial_out_line;
    neg_oe_q <= serial_out_oe;
  end

  always_ff @(posedge clk) begin
    bcnt_q <= prog_busy ? bcnt_q + 17'h00001 : 17'h00000;
  end

  oe_released_a: assert property (@(posedge clk)
    disable iff (!rst_n) !chip_select |-> !serial_out_oe)
    else $error("output driven while deselected");
  busy_needs_en_a: assert property (@(posedge clk)
    disable iff (!rst_n) $rose(prog_busy) |-> prog_enabled)
    else $error("program cycle without enable");
  // one cycle of slack for the request crossing
  cycle_len_a: assert property (@(posedge clk)
    disable iff (!rst_n) $fell(prog_busy) |->
    bcnt_q + 1 >= TWP_CYC && bcnt_q <= TWP_CYC + 1)
    else $error("program cycle length wrong");
  busy_zero_a: assert property (@(posedge clk)
    disable iff (!rst_n) serial_out_oe && prog_busy |-> !serial_out_line)
    else $error("busy not shown as zero");
  ready_one_a: assert property (@(posedge clk)
    disable iff (!rst_n) serial_out_oe && $fell(prog_busy)
    |-> serial_out_line)
    else $error("ready not shown as one");
  status_on_a: assert property (@(posedge clk)
    disable iff (!rst_n) !chip_select [*8] ##1 (chip_select && prog_busy)
    |-> ##[1:5] (serial_out_oe || !prog_busy))
    else $error("status not presented");
  out_on_rise_a: assert property (@(posedge serial_shift_clock)
    disable iff (!rst_n) serial_out_oe && neg_oe_q && !prog_busy
    |-> serial_out_line == neg_q)
    else $error("output changed off rising edge");
  dummy_first_a: assert property (@(negedge serial_shift_clock)
    disable iff (!rst_n) $rose(serial_out_oe) && !prog_busy
    |-> !serial_out_line)
    else $error("leading bit not zero");
endmodule

bind eec_engine eec_engine_props #(.TWP_CYC(TWP_CYC)) u_props (
  .clk(clk), .rst_n(rst_n), .serial_shift_clock(serial_shift_clock),
  .chip_select(chip_select), .serial_in_line(serial_in_line),
  .width_select_pin(width_select_pin), .serial_out_line(serial_out_line),
  .serial_out_oe(serial_out_oe), .prog_enabled(prog_enabled),
  .prog_busy(prog_busy));

// *** eec_host.sv ***
// eec_host: host controller model on the three-wire link.
// assumes a 30 ns shift clock that stands still between frames.
`timescale 1ns/1ps
module eec_host (
  output logic     serial_shift_clock,
  output logic     chip_select,
  output logic     serial_in_line,
  input wire logic serial_out_line,
  input wire logic serial_out_oe
);
  // released line seen as the inverse so a missing enable shows up
  wire line_seen = serial_out_oe ? serial_out_line : ~serial_out_line;
  initial begin
    serial_shift_clock = 1'b0;
    chip_select        = 1'b0;
    serial_in_line     = 1'b0;
  end

  task automatic xfer(input logic [39:0] bits, input int n,
                      input int nrd, output logic [63:0] rd);
    rd = 64'h0;
    chip_select = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line = bits[i];
      #15 serial_shift_clock = 1'b1;
      #15 serial_shift_clock = 1'b0;
    end
    rd = {rd[62:0], line_seen};
    for (int i = 0; i < nrd; i++) begin
      #15 serial_shift_clock = 1'b1;
      #15 serial_shift_clock = 1'b0;
      rd = {rd[62:0], line_seen};
    end
    #15 chip_select = 1'b0;
    // flip the line so no stale bit looks valid
    serial_in_line = ~serial_in_line;
    #400;
  endtask

  task automatic status(input int hold, output logic st, output logic oe,
                        output logic fin);
    chip_select = 1'b1;
    #240 st = line_seen;
    oe = serial_out_oe;
    // a long hold watches busy turn into ready under one select
    #(40 + hold) fin = line_seen;
    chip_select = 1'b0;
    #400;
  endtask
endmodule

// *** eec_engine_tb.sv ***
// eec_engine_tb: random and corner traffic against a byte model.
// assumes the host model drives the link; clk at 25 MHz.
`timescale 1ns/1ps
module eec_engine_tb;
  import eec_pkg::*;
  localparam int unsigned SELF_TIMED_CYCLE_TIME = 60;
  logic        clk, rst_n, sk, cs, di, wsel, dout, doe, pen, pbusy;
  logic        st, so, fin;
  logic [7:0]  mem [512];
  logic [63:0] rd;
  logic [15:0] d, mk;
  logic [8:0]  a, top;
  int          err_count, cmp_count;

  eec_engine #(.TWP_CYC(SELF_TIMED_CYCLE_TIME)) u_eec_engine (.clk(clk), .rst_n(rst_n),
    .serial_shift_clock(sk), .chip_select(cs), .serial_in_line(di),
    .width_select_pin(wsel), .serial_out_line(dout),
    .serial_out_oe(doe), .prog_enabled(pen), .prog_busy(pbusy));
  eec_host u_eec_host (.serial_shift_clock(sk), .chip_select(cs),
    .serial_in_line(di), .serial_out_line(dout), .serial_out_oe(doe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [8:0] ext(input logic [1:0] sub);
    return wsel ? {1'b0, sub, 6'h00} : {sub, 7'h00};
  endfunction

  function automatic logic [15:0] expw(input int ad);
    if (wsel) return {mem[2 * ad + 1], mem[2 * ad]};
    return {8'h00, mem[ad]};
  endfunction

  task automatic put(input logic [8:0] ad, input logic [15:0] v);
    if (wsel) begin
      mem[2 * ad]     = v[7:0];
      mem[2 * ad + 1] = v[15:8];
    end else mem[ad] = v[7:0];
  endtask

  task automatic cmd(input logic [1:0] op, input logic [8:0] adr,
                     input logic [15:0] dat, input bit hasd, input int nw);
    logic [39:0] b;
    int          al;
    int          n;
    al = wsel ? 8 : 9;
    b  = {37'h0, START_MARKER_BIT, op};
    b  = (b << al) | 40'(adr);
    n  = 3 + al;
    if (hasd) begin
      b = (b << (al + 8 - 1 - al + 1 + (wsel ? 8 : 0))) | 40'(dat);
      n = n + (wsel ? 16 : 8);
    end
    u_eec_host.xfer(b, n, nw * (wsel ? 16 : 8), rd);
    // back on a falling edge so flag compares never race the clock
    @(negedge clk);
  endtask

  task automatic rdchk(input logic [8:0] adr, input int nw);
    int w;
    w = wsel ? 16 : 8;
    cmd(OPC_READ, adr, 16'h0000, 1'b0, nw);
    check("dummy bit", 16'(rd[nw * w]), 16'h0000);
    for (int k = 0; k < nw; k++) begin
      check("read word", 16'(rd >> ((nw - 1 - k) * w)) & mk,
            expw((adr + k) % (wsel ? 256 : 512)));
    end
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (pbusy !== 1'b0) begin
      @(negedge clk);
      k++;
      if (k > 1000) begin
        err_count++;
        tally_and_finish;
      end
    end
  endtask

  initial begin
    rst_n = 1'b0;
    wsel = 1'b0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(9063));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("enable at start", pen, 0);
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      wsel = m[0];
      mk = wsel ? 16'hFFFF : 16'h00FF;
      top = wsel ? 9'h0FF : 9'h1FF;
      cmd(OPC_WRITE, 9'h005, 16'h00A5, 1'b1, 0);
      check("busy while off", pbusy, 0);
      cmd(OPC_EXT, ext(SUB_ENABLE), 16'h0000, 1'b0, 0);
      check("enable latch", pen, 1);
      cmd(OPC_EXT, ext(SUB_ERASE_ALL), 16'h0000, 1'b0, 0);
      u_eec_host.status(SELF_TIMED_CYCLE_TIME * 40, st, so, fin);
      check("status busy", {so, st}, 16'h0002);
      check("status ready", fin, 1);
      wait_idle;
      u_eec_host.status(0, st, so, fin);
      check("late status", so, 0);
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      for (int k = 0; k < 4; k++) begin
        a = 9'($urandom) & top;
        d = 16'($urandom) & mk;
        cmd(OPC_WRITE, a, d, 1'b1, 0);
        put(a, d);
        // lands while busy, must be dropped
        cmd(OPC_WRITE, (a + 9'h001) & top, ~d & mk, 1'b1, 0);
        wait_idle;
        rdchk((a - 9'h001) & top, 3);
      end
      cmd(OPC_ERASE, top, 16'h0000, 1'b0, 0);
      put(top, 16'hFFFF);
      wait_idle;
      rdchk(top - 9'h001, 3);
      d = 16'($urandom) & mk;
      cmd(OPC_EXT, ext(SUB_WRITE_ALL), d, 1'b1, 0);
      foreach (mem[i]) mem[i] = (wsel && i[0]) ? d[15:8] : d[7:0];
      wait_idle;
      rdchk(9'($urandom) & top, 1 + $urandom % 3);
      check("enable held", pen, 1);
      cmd(OPC_EXT, ext(SUB_DISABLE), 16'h0000, 1'b0, 0);
      check("enable cleared", pen, 0);
      cmd(OPC_WRITE, 9'h003, ~d & mk, 1'b1, 0);
      check("busy after off", pbusy, 0);
      rdchk(9'h002, 2);
      check("oe idle", doe, 0);
      $display("test width %0d done", m);
    end
    tally_and_finish;
  end
endmodule
